/* File: core/emu_break_ctrl.sv */
/*
 * Break, single-step, interrupt hold and trace qualification for an emulator
 * watching a 4-bit core. Assumes ret_valid_i pulses once per retired (or
 * skipped) instruction and that all inputs are synchronous to core_clk_i.
 */
`default_nettype none
module emu_break_ctrl
	import emu_break_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ret_valid_i,
	input wire retire_t ret_i,
	input wire logic pc_break_hit_i,
	input wire logic wr_event_hit_i,
	input wire logic rd_event_hit_i,
	input wire logic check_hit_i,
	input wire logic trace_delay_period_i,
	input wire logic irq_req_i,
	input wire logic step_mode_i,
	input wire logic standby_i,
	input wire logic resume_i,
	output logic break_req_o,
	output logic irq_accept_o,
	output logic interrupt_request_flag_o,
	output logic standby_release_o,
	output logic trace_valid_o,
	output trace_rec_t trace_rec_o
);
	brk_state_t state_ff;
	logic [1:0] slip_ff;
	logic wr_pend_ff;
	logic chk_hold_ff;
	logic brk_ff;
	logic irq_acc_ff;
	logic irq_flag_ff;
	logic rel_ff;
	logic tv_ff;
	trace_rec_t rec_ff;
	logic pc_or_rd;

	assign pc_or_rd = pc_break_hit_i | rd_event_hit_i;

	// Break sequencer: count slip instructions, stop on a boundary
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= RUN;
			slip_ff <= SLIP_NONE;
			wr_pend_ff <= 1'b0;
			brk_ff <= 1'b0;
		end else begin
			case (state_ff)
				RUN: begin
					if (ret_valid_i && pc_break_hit_i && !ret_i.flag_bank) begin
						brk_ff <= 1'b1;
						state_ff <= STOPPED;
					end else if (ret_valid_i && wr_event_hit_i) begin
						wr_pend_ff <= 1'b1;
						state_ff <= SLIP;
					end else if (ret_valid_i && (pc_or_rd || (pc_break_hit_i && ret_i.flag_bank))) begin
						slip_ff <= SLIP_ONE;
						state_ff <= SLIP;
					end
				end
				SLIP: begin
					if (ret_valid_i) begin
						if (wr_pend_ff) begin
							wr_pend_ff <= 1'b0;
							if (ret_i.len == 2'h1) begin
								slip_ff <= SLIP_ONE;
							end else begin
								brk_ff <= 1'b1;
								state_ff <= STOPPED;
							end
						end else if (ret_i.flag_bank) begin
							slip_ff <= SLIP_ONE;
						end else if (slip_ff == SLIP_ONE) begin
							slip_ff <= SLIP_NONE;
							brk_ff <= 1'b1;
							state_ff <= STOPPED;
						end
					end
				end
				STOPPED: begin
					if (resume_i) begin
						brk_ff <= 1'b0;
						state_ff <= RUN;
					end
				end
				default: begin
					state_ff <= RUN;
					brk_ff <= 1'b0;
				end
			endcase
		end
	end

	// Interrupt hold across check matches
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_hold_ff <= 1'b0;
		end else if (ret_valid_i) begin
			chk_hold_ff <= check_hit_i;
		end
	end

	// Request flag: set wins over the acceptance clear
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_flag_ff <= 1'b0;
			irq_acc_ff <= 1'b0;
		end else begin
			irq_acc_ff <= 1'b0;
			if (irq_req_i) begin
				irq_flag_ff <= 1'b1;
			end else if (irq_flag_ff && ret_valid_i && !check_hit_i && !chk_hold_ff
					&& !step_mode_i && state_ff != STOPPED) begin
				irq_flag_ff <= 1'b0;
				irq_acc_ff <= 1'b1;
			end
		end
	end

	// Single-step never leaves the core in standby
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rel_ff <= 1'b0;
		end else begin
			rel_ff <= step_mode_i & standby_i;
		end
	end

	// Qualified trace
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tv_ff <= 1'b0;
			rec_ff <= '0;
		end else begin
			tv_ff <= ret_valid_i & check_hit_i & !trace_delay_period_i;
			if (ret_valid_i) begin
				rec_ff.pc <= ret_i.pc;
				rec_ff.skip_flag <= 1'b0;
				rec_ff.mem_addr <= ret_i.mem_addr;
				// Trace tap sees stale bus data on these two
				if (ret_i.mem_rd && (ret_i.mem_addr == BANK_SEL_ADDR
						|| ret_i.mem_addr == STATUS_ADDR)) begin
					rec_ff.mem_data <= TRACE_FILL;
				end else begin
					rec_ff.mem_data <= ret_i.mem_data;
				end
			end
		end
	end

	assign break_req_o = brk_ff;
	assign irq_accept_o = irq_acc_ff;
	assign interrupt_request_flag_o = irq_flag_ff;
	assign standby_release_o = rel_ff;
	assign trace_valid_o = tv_ff;
	assign trace_rec_o = rec_ff;

	property p_trace_delay;
		@(posedge core_clk_i) disable iff (!resetn_i)
		trace_delay_period_i |=> !trace_valid_o;
	endproperty
	a_trace_delay: assert property (p_trace_delay) else $error("trace in delay");

	property p_no_skip;
		@(posedge core_clk_i) disable iff (!resetn_i)
		trace_valid_o |-> !trace_rec_o.skip_flag;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("skip reported");

	property p_step_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		step_mode_i |=> !irq_accept_o;
	endproperty
	a_step_irq: assert property (p_step_irq) else $error("irq in step");

	property p_irq_flag;
		@(posedge core_clk_i) disable iff (!resetn_i)
		irq_req_i |=> interrupt_request_flag_o;
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("flag lost");

	property p_chk_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ret_valid_i && check_hit_i) |=> !irq_accept_o;
	endproperty
	a_chk_irq: assert property (p_chk_irq) else $error("irq at check");

	property p_release;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(step_mode_i && standby_i) |=> standby_release_o;
	endproperty
	a_release: assert property (p_release) else $error("no release");

	property p_pc_brk;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == RUN && ret_valid_i && pc_break_hit_i && !ret_i.flag_bank)
			|=> break_req_o;
	endproperty
	a_pc_brk: assert property (p_pc_brk) else $error("pc break late");

	property p_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(break_req_o && !resume_i) |=> break_req_o;
	endproperty
	a_hold: assert property (p_hold) else $error("break dropped");

	property p_rd_slip;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == RUN && ret_valid_i && rd_event_hit_i && !pc_break_hit_i
			&& !wr_event_hit_i) |=> !break_req_o;
	endproperty
	a_rd_slip: assert property (p_rd_slip) else $error("read break no slip");

	property p_boundary;
		@(posedge core_clk_i) disable iff (!resetn_i)
		$rose(break_req_o) |-> $past(ret_valid_i);
	endproperty
	a_boundary: assert property (p_boundary) else $error("break off boundary");

	property p_resume;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(break_req_o && resume_i) |=> !break_req_o;
	endproperty
	a_resume: assert property (p_resume) else $error("resume ignored");

	property p_wr_len1;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == SLIP && wr_pend_ff && ret_valid_i && ret_i.len == 2'h1) |=> !break_req_o;
	endproperty
	a_wr_len1: assert property (p_wr_len1) else $error("write slip short");

	property p_wr_len23;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == SLIP && wr_pend_ff && ret_valid_i && ret_i.len != 2'h1) |=> break_req_o;
	endproperty
	a_wr_len23: assert property (p_wr_len23) else $error("write slip long");

	property p_fb_slip;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == RUN && ret_valid_i && pc_break_hit_i && ret_i.flag_bank
			&& !wr_event_hit_i) |=> !break_req_o;
	endproperty
	a_fb_slip: assert property (p_fb_slip) else $error("flag break no slip");

	property p_fb_chain;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == SLIP && !wr_pend_ff && ret_valid_i && ret_i.flag_bank) |=> !break_req_o;
	endproperty
	a_fb_chain: assert property (p_fb_chain) else $error("flag chain cut");

	property p_slip_end;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_ff == SLIP && !wr_pend_ff && slip_ff == SLIP_ONE && ret_valid_i
			&& !ret_i.flag_bank) |=> break_req_o;
	endproperty
	a_slip_end: assert property (p_slip_end) else $error("slip never ends");

	property p_chk_next;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ret_valid_i && chk_hold_ff) |=> !irq_accept_o;
	endproperty
	a_chk_next: assert property (p_chk_next) else $error("irq after check");

	property p_stop_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		break_req_o |=> !irq_accept_o;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("irq while held");

	property p_step_flag;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(step_mode_i && interrupt_request_flag_o) |=> interrupt_request_flag_o;
	endproperty
	a_step_flag: assert property (p_step_flag) else $error("flag cleared in step");

	property p_rel_off;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!standby_i |=> !standby_release_o;
	endproperty
	a_rel_off: assert property (p_rel_off) else $error("spurious release");

	property p_trace_fill;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ret_valid_i && ret_i.mem_rd && ret_i.mem_addr == STATUS_ADDR)
			|=> trace_rec_o.mem_data == TRACE_FILL;
	endproperty
	a_trace_fill: assert property (p_trace_fill) else $error("status read traced");

	property p_trace_qual;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ret_valid_i && check_hit_i && !trace_delay_period_i) |=> trace_valid_o;
	endproperty
	a_trace_qual: assert property (p_trace_qual) else $error("check not traced");

	property p_trace_idle;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!ret_valid_i |=> !trace_valid_o;
	endproperty
	a_trace_idle: assert property (p_trace_idle) else $error("trace without retire");

	// Acceptance is a single pulse; the flag must be consumed with it
	property p_acc_pulse;
		@(posedge core_clk_i) disable iff (!resetn_i)
		irq_accept_o |=> !irq_accept_o;
	endproperty
	a_acc_pulse: assert property (p_acc_pulse) else $error("accept repeated");

	property p_acc_clear;
		@(posedge core_clk_i) disable iff (!resetn_i)
		irq_accept_o |-> !interrupt_request_flag_o;
	endproperty
	a_acc_clear: assert property (p_acc_clear) else $error("flag kept on accept");
endmodule
`default_nettype wire

/* File: pkg/emu_break_pkg.sv */
/*
 * Constants and carrier types for the emulator break and trace control.
 * Assumes a single 20 MHz clock and a core that reports instruction retirement.
 */
`default_nettype none
package emu_break_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 4;
	localparam logic [ADDR_W-1:0] BANK_SEL_ADDR = 12'hf82;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'hfb0;
	localparam logic [1:0] SLIP_NONE = 2'h0;
	localparam logic [1:0] SLIP_ONE = 2'h1;
	localparam logic [1:0] SLIP_TWO = 2'h2;
	localparam logic [DATA_W-1:0] TRACE_FILL = 4'h0;

	// One retired instruction as reported by the core
	typedef struct packed {
		logic [ADDR_W-1:0] pc;
		logic [1:0] len;
		logic skipped;
		logic flag_bank;
		logic mem_wr;
		logic mem_rd;
		logic [ADDR_W-1:0] mem_addr;
		logic [DATA_W-1:0] mem_data;
	} retire_t;

	// One record handed to trace memory
	typedef struct packed {
		logic [ADDR_W-1:0] pc;
		logic skip_flag;
		logic [ADDR_W-1:0] mem_addr;
		logic [DATA_W-1:0] mem_data;
	} trace_rec_t;

	typedef enum logic [1:0] {RUN, SLIP, STOPPED} brk_state_t;
endpackage
`default_nettype wire

/* File: verification/core_model.sv */
/*
 * Behavioural model of the watched core: retires one instruction a request.
 * Assumes the bench paces requests and holds them no more than one cycle.
 */
`default_nettype none
module core_model
	import emu_break_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic go_i,
	input wire logic stop_i,
	input wire retire_t instr_i,
	input wire logic [3:0] hit_i,
	output logic ret_valid_o,
	output retire_t ret_o,
	output logic [3:0] hit_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Held core retires nothing; its programs never exchange on special regs
	always_ff @(posedge core_clk_i) begin
		ret_valid_o <= go_i & ~stop_i;
		// Idle bus shows the inverse so no stale record looks valid
		ret_o <= go_i ? instr_i : ~instr_i;
		hit_o <= go_i ? hit_i : 4'h0;
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * Bench for break slip, interrupt hold, step standby release and trace.
 * Assumes core_model stands between the stimulus and the retire port.
 */
`default_nettype none
module tb_top
	import emu_break_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic dly = 1'b0;
	logic irq = 1'b0;
	logic step = 1'b0;
	logic sby = 1'b0;
	logic res = 1'b0;
	logic [3:0] hit = 4'h0;
	logic [ADDR_W-1:0] ma = 12'h020;
	retire_t ins = '0;
	logic rv, brk, acc, flg, rel, tv;
	retire_t r;
	logic [3:0] h;
	trace_rec_t tr;
	int num_errors = 0;
	int compares = 0;
	int n;
	// Row: hits {wr,rd,pc,chk}, flags {fb,skip,next fb}, next len, retires to break
	logic [15:0] rows [9] = '{16'h8012, 16'h8021, 16'h8031, 16'h4011, 16'h4031,
		16'h2010, 16'h2411, 16'h2512, 16'h2210};
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	core_model core_model_i(.core_clk_i(core_clk), .go_i(go), .stop_i(brk), .instr_i(ins),
		.hit_i(hit), .ret_valid_o(rv), .ret_o(r), .hit_o(h));
	emu_break_ctrl emu_break_ctrl_i(.core_clk_i(core_clk), .resetn_i(rst_n), .ret_valid_i(rv),
		.ret_i(r), .pc_break_hit_i(h[1]), .wr_event_hit_i(h[3]), .rd_event_hit_i(h[2]),
		.check_hit_i(h[0]), .trace_delay_period_i(dly), .irq_req_i(irq), .step_mode_i(step),
		.standby_i(sby), .resume_i(res), .break_req_o(brk), .irq_accept_o(acc),
		.interrupt_request_flag_o(flg), .standby_release_o(rel), .trace_valid_o(tv),
		.trace_rec_o(tr));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Outputs are looked at 1 ns after the edge on which the controller takes the retire
	task automatic ret(input logic [1:0] len, input logic [2:0] f, input logic [3:0] hv);
		@(posedge core_clk);
		ins <= '{pc: 12'h010, len: len, skipped: f[1], flag_bank: f[2], mem_wr: hv[3],
			mem_rd: ~hv[3], mem_addr: ma, mem_data: 4'h5};
		hit <= hv;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		chk({brk, acc, flg, rel, tv}, 8'h00);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk({brk, acc, flg, rel, tv}, 8'h00);
		foreach (rows[i]) begin
			ret(2'h1, rows[i][10:8], rows[i][15:12]);
			n = 0;
			while (brk !== 1'b1 && n < 4) begin
				ret(n == 0 ? rows[i][5:4] : 2'h1, {n == 0 && rows[i][8], 2'h0}, 4'h0);
				n++;
			end
			chk(8'(n), {5'h0, rows[i][2:0]});
			if (n == 4)
				summarize();
			@(posedge core_clk);
			#1;
			chk(brk, 1'b1);
			@(posedge core_clk) res <= 1'b1;
			@(posedge core_clk) res <= 1'b0;
			@(posedge core_clk);
			#1;
			chk(brk, 1'b0);
		end
		$display("break slip rows done");
		ma <= STATUS_ADDR;
		ret(2'h1, 3'h2, 4'h1);
		chk(tv, 1'b1);
		chk(tr.skip_flag, 1'b0);
		chk(tr.pc[7:0], 8'h10);
		chk(tr.mem_data, TRACE_FILL);
		dly <= 1'b1;
		ret(2'h1, 3'h0, 4'h1);
		chk(tv, 1'b0);
		dly <= 1'b0;
		$display("trace done");
		@(posedge core_clk) step <= 1'b1;
		@(posedge core_clk) irq <= 1'b1;
		@(posedge core_clk) irq <= 1'b0;
		ret(2'h1, 3'h0, 4'h0);
		chk({acc, flg}, 8'h01);
		@(posedge core_clk) step <= 1'b0;
		ret(2'h1, 3'h0, 4'h0);
		chk(acc, 1'b1);
		@(posedge core_clk) irq <= 1'b1;
		@(posedge core_clk) irq <= 1'b0;
		ret(2'h2, 3'h0, 4'h1);
		chk(acc, 1'b0);
		ret(2'h1, 3'h0, 4'h0);
		chk(acc, 1'b0);
		ret(2'h1, 3'h0, 4'h0);
		chk(acc, 1'b1);
		@(posedge core_clk) irq <= 1'b1;
		@(posedge core_clk) irq <= 1'b0;
		ret(2'h1, 3'h0, 4'h1);
		ret(2'h1, 3'h0, 4'h1);
		chk(acc, 1'b0);
		ret(2'h1, 3'h0, 4'h0);
		chk(acc, 1'b0);
		ret(2'h1, 3'h0, 4'h0);
		chk(acc, 1'b1);
		$display("interrupt hold done");
		@(posedge core_clk) step <= 1'b1;
		@(posedge core_clk) sby <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk(rel, 1'b1);
		$display("standby release done");
		summarize();
	end
endmodule
`default_nettype wire
